// ### trim_swap_pkg.sv
package trim_swap_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_REFERENCE_TRIM = 12'h07C;
  localparam logic [11:0] OFS_TERM_TRIM_A = 12'h07E;
  localparam logic [11:0] OFS_TERM_TRIM_B = 12'h07F;
  localparam logic [11:0] OFS_TERM_TRIM_C = 12'h080;
  localparam logic [11:0] OFS_TERM_TRIM_D = 12'h081;
  localparam logic [11:0] OFS_SWAP_OVERLAP_DELAY = 12'h09A;
  localparam logic [11:0] OFS_SWAP_STEERING_DELAY = 12'h09B;
  localparam logic [11:0] OFS_DITHER_CONTROL = 12'h09D;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int REF_TRIM_W = 4;
  localparam int DELAY_W = 5;
  localparam int DITHER_ON_BIT = 0;
  localparam int DITHER_LARGE_BIT = 1;
  localparam int ROUNDING_BIT = 2;
  localparam logic [3:0] RST_REFERENCE_TRIM = 4'h0;
  localparam logic [7:0] RST_TERM_TRIM = 8'h00;
  localparam logic [4:0] RST_OVERLAP_DELAY = 5'h08;
  localparam logic [4:0] RST_STEERING_DELAY = 5'h07;
  localparam logic [2:0] RST_DITHER = 3'h0;

  // ------------------------------------------------------------
  // swap timing: overlap lasts OVERLAP_BASE + 2 * delay cycles
  // ------------------------------------------------------------
  localparam logic [6:0] OVERLAP_BASE = 7'h04;
  localparam int SWAP_CNT_W = 7;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] reference_trim_field;
    logic [7:0] term_trim_a;
    logic [7:0] term_trim_b;
    logic [7:0] term_trim_c;
    logic [7:0] term_trim_d;
    logic [2:0] dither_ctrl;
  } fuse_image_t;

  typedef struct packed {
    logic [3:0] reference_trim_field;
    logic [7:0] term_trim_a;
    logic [7:0] term_trim_b;
    logic [7:0] term_trim_c;
    logic [7:0] term_trim_d;
    logic [4:0] overlap_delay;
    logic [4:0] steering_delay;
    logic dither_on;
    logic dither_large;
    logic rounding_to_offset;
  } trim_cfg_t;

  typedef enum logic [1:0] {
    SWAP_IDLE = 2'b01,
    SWAP_OVERLAP = 2'b10
  } swap_state_t;

endpackage

// ### adc_trim_swap_dither_regs.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
// ------------------------------------------------------------
// How it works
// RULE1: software writes reserved bits as zero; they are not stored, read zero.
// RULE2: trims and dither take their contents from fuse image after reset.
// RULE3: reference trim is bits 3:0, fuse-loaded, readable and writable.
// RULE4: four full-byte termination trims, fuse-loaded, readable and writable.
// RULE5: software changes overlap delay only while calibration is off.
// RULE6: swap overlap lasts four plus twice the overlap delay converter cycles.
// RULE7: overlap delay is bits 4:0, values 0 to 31, reset eight.
// RULE8: software may pick seven at a slow clock, accepting glitch risk.
// RULE9: steering select is delayed by steering delay, only during swaps, reset seven.
// RULE10: software tunes steering delay to land inside both-valid interval.
// RULE11: dither register bit 0 enables dither injection.
// RULE12: dither register bit 1 selects large dither when set.
// RULE13: dither register bit 2 sends rounding error to offset and spurs.
// ------------------------------------------------------------
module adc_trim_swap_dither_regs
  import trim_swap_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire fuse_image_t fuse_image,
  output trim_cfg_t cfg,
  input wire logic swap_start,
  input wire logic swap_sel_in,
  output logic swap_busy,
  output logic swap_overlap,
  output logic steer_sel
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  // the highest offset needs eight address bits;
  // the decode compares against twelve-bit offsets
  generate
    if (ADDR_W < 8 || ADDR_W > 12) begin : g_bad_addr_w
      $error("ADDR_W must lie between 8 and 12");
    end
  endgenerate

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [3:0] ref_trim_r;
  logic [7:0] term_a_r;
  logic [7:0] term_b_r;
  logic [7:0] term_c_r;
  logic [7:0] term_d_r;
  logic [4:0] overlap_r;
  logic [4:0] steering_r;
  logic [2:0] dither_r;
  logic fuse_pending_r;
  logic [7:0] rdata_r;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire logic [11:0] addr_ext = 12'(reg_addr);
  wire logic hit_ref = (addr_ext == OFS_REFERENCE_TRIM);
  wire logic hit_a = (addr_ext == OFS_TERM_TRIM_A);
  wire logic hit_b = (addr_ext == OFS_TERM_TRIM_B);
  wire logic hit_c = (addr_ext == OFS_TERM_TRIM_C);
  wire logic hit_d = (addr_ext == OFS_TERM_TRIM_D);
  wire logic hit_ovl = (addr_ext == OFS_SWAP_OVERLAP_DELAY);
  wire logic hit_str = (addr_ext == OFS_SWAP_STEERING_DELAY);
  wire logic hit_dith = (addr_ext == OFS_DITHER_CONTROL);

  // write strobes; reserved upper bits are dropped on write
  wire logic wr_ref = reg_wr && hit_ref;
  wire logic wr_a = reg_wr && hit_a;
  wire logic wr_b = reg_wr && hit_b;
  wire logic wr_c = reg_wr && hit_c;
  wire logic wr_d = reg_wr && hit_d;
  wire logic wr_ovl = reg_wr && hit_ovl;
  wire logic wr_str = reg_wr && hit_str;
  wire logic wr_dith = reg_wr && hit_dith;

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  // RULE2: fuse image overrides at first edge after release
  // RULE3: reference trim low nibble
  wire logic [3:0] ref_trim_nxt = fuse_pending_r ? fuse_image.reference_trim_field :
                                  wr_ref ? reg_wdata[REF_TRIM_W-1:0] : ref_trim_r;
  // RULE4: per-input termination bytes
  wire logic [7:0] term_a_nxt = fuse_pending_r ? fuse_image.term_trim_a :
                                wr_a ? reg_wdata : term_a_r;
  wire logic [7:0] term_b_nxt = fuse_pending_r ? fuse_image.term_trim_b :
                                wr_b ? reg_wdata : term_b_r;
  wire logic [7:0] term_c_nxt = fuse_pending_r ? fuse_image.term_trim_c :
                                wr_c ? reg_wdata : term_c_r;
  wire logic [7:0] term_d_nxt = fuse_pending_r ? fuse_image.term_trim_d :
                                wr_d ? reg_wdata : term_d_r;
  // RULE7: five-bit overlap delay field
  wire logic [4:0] overlap_nxt = wr_ovl ? reg_wdata[DELAY_W-1:0] : overlap_r;
  // RULE9: five-bit steering delay field
  wire logic [4:0] steering_nxt = wr_str ? reg_wdata[DELAY_W-1:0] : steering_r;
  // RULE2: dither controls also fuse-loaded
  wire logic [2:0] dither_nxt = fuse_pending_r ? fuse_image.dither_ctrl :
                                wr_dith ? reg_wdata[ROUNDING_BIT:0] : dither_r;

  // ------------------------------------------------------------
  // read mux; unmapped and reserved bits read zero
  // ------------------------------------------------------------
  // RULE1: reserved bits return their zero default
  wire logic [7:0] rd_mux =
    hit_ref ? {4'h0, ref_trim_r} :
    hit_a ? term_a_r :
    hit_b ? term_b_r :
    hit_c ? term_c_r :
    hit_d ? term_d_r :
    hit_ovl ? {3'h0, overlap_r} :
    hit_str ? {3'h0, steering_r} :
    hit_dith ? {5'h00, dither_r} : 8'h00;
  wire logic [7:0] rdata_nxt = reg_rd ? rd_mux : 8'h00;

  // ------------------------------------------------------------
  // register processes
  // ------------------------------------------------------------
  // fuse load request, cleared after one edge
  // RULE2: set in reset so the first edge after release loads fuses
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fuse_pending_r <= 1'b1;
    end else begin
      fuse_pending_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // trim registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_trim_r <= RST_REFERENCE_TRIM;
      term_a_r <= RST_TERM_TRIM;
      term_b_r <= RST_TERM_TRIM;
      term_c_r <= RST_TERM_TRIM;
      term_d_r <= RST_TERM_TRIM;
    end else begin
      ref_trim_r <= ref_trim_nxt;
      term_a_r <= term_a_nxt;
      term_b_r <= term_b_nxt;
      term_c_r <= term_c_nxt;
      term_d_r <= term_d_nxt;
    end
  end

  // ------------------------------------------------------------
  // swap delays and dither
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      overlap_r <= RST_OVERLAP_DELAY;
      steering_r <= RST_STEERING_DELAY;
      dither_r <= RST_DITHER;
    end else begin
      overlap_r <= overlap_nxt;
      steering_r <= steering_nxt;
      dither_r <= dither_nxt;
    end
  end

  // ------------------------------------------------------------
  // read data, valid the cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ------------------------------------------------------------
  // configuration out
  // ------------------------------------------------------------
  always_comb begin
    cfg.reference_trim_field = ref_trim_r;
    cfg.term_trim_a = term_a_r;
    cfg.term_trim_b = term_b_r;
    cfg.term_trim_c = term_c_r;
    cfg.term_trim_d = term_d_r;
    cfg.overlap_delay = overlap_r;
    cfg.steering_delay = steering_r;
    // RULE11: dither enable bit
    cfg.dither_on = dither_r[DITHER_ON_BIT];
    // RULE12: dither amplitude select
    cfg.dither_large = dither_r[DITHER_LARGE_BIT];
    // RULE13: rounding error destination
    cfg.rounding_to_offset = dither_r[ROUNDING_BIT];
  end

  // ------------------------------------------------------------
  // background swap sequencer
  // ------------------------------------------------------------
  swap_state_t state_r;
  swap_state_t state_nxt;
  logic [SWAP_CNT_W-1:0] ovl_cnt_r;
  logic [SWAP_CNT_W-1:0] ovl_cnt_nxt;
  logic [SWAP_CNT_W-1:0] str_cnt_r;
  logic [SWAP_CNT_W-1:0] str_cnt_nxt;
  logic steer_r;
  logic steer_nxt;
  logic target_r;
  logic target_nxt;

  // RULE6: overlap length 4 + 2 * delay, taken at swap start
  wire logic [SWAP_CNT_W-1:0] ovl_len = OVERLAP_BASE + {1'b0, overlap_r, 1'b0};
  wire logic start_ok = swap_start && (state_r == SWAP_IDLE);
  // RULE6: countdown at zero marks the last overlap cycle
  wire logic ovl_last = (ovl_cnt_r == 7'h00);
  // RULE9: steering countdown running, and its final step
  wire logic str_run = (str_cnt_r != 7'h00);
  wire logic str_last = (str_cnt_r == 7'h01);

  // state, counters and steering select
  always_comb begin
    state_nxt = state_r;
    ovl_cnt_nxt = ovl_cnt_r;
    str_cnt_nxt = str_cnt_r;
    steer_nxt = steer_r;
    target_nxt = target_r;
    unique case (state_r)
      SWAP_IDLE: begin
        if (start_ok) begin
          state_nxt = SWAP_OVERLAP;
          ovl_cnt_nxt = ovl_len - 7'h01;
          str_cnt_nxt = {2'b00, steering_r};
          target_nxt = swap_sel_in;
          // RULE9: zero delay steers at once
          if (steering_r == 5'h00) begin
            steer_nxt = swap_sel_in;
          end
        end
      end
      SWAP_OVERLAP: begin
        // RULE9: steering moves after programmed delay
        if (str_run) begin
          str_cnt_nxt = str_cnt_r - 7'h01;
          if (str_last) begin
            steer_nxt = target_r;
          end
        end
        // RULE6: end overlap after full count
        if (ovl_last) begin
          state_nxt = SWAP_IDLE;
          steer_nxt = target_r;
        end else begin
          ovl_cnt_nxt = ovl_cnt_r - 7'h01;
        end
      end
      default: begin
        state_nxt = SWAP_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // sequencer state and counters
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SWAP_IDLE;
      ovl_cnt_r <= 7'h00;
      str_cnt_r <= 7'h00;
      steer_r <= 1'b0;
      target_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ovl_cnt_r <= ovl_cnt_nxt;
      str_cnt_r <= str_cnt_nxt;
      steer_r <= steer_nxt;
      target_r <= target_nxt;
    end
  end

  // ------------------------------------------------------------
  // swap outputs
  // ------------------------------------------------------------
  // RULE6: both cores share the input for the whole overlap
  assign swap_busy = (state_r == SWAP_OVERLAP);
  assign swap_overlap = (state_r == SWAP_OVERLAP);
  assign steer_sel = steer_r;

  // ------------------------------------------------------------
  // limits for software
  // ------------------------------------------------------------
  // delays latched at swap start; mid-swap writes shape the next swap
  // no calibration interlock on overlap writes; software keeps to it
  // a trim or dither write in the first cycle after release loses to the fuse load
  // a swap request during an overlap is dropped without notice

endmodule

// ### adc_trim_swap_dither_regs_assertions.sv
`timescale 1ns/10ps
module trim_regs_checker
  import trim_swap_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire fuse_image_t fuse_image,
  input wire trim_cfg_t cfg,
  input wire logic swap_start,
  input wire logic swap_sel_in,
  input wire logic swap_busy,
  input wire logic swap_overlap,
  input wire logic steer_sel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [6:0] len_r;
  logic [6:0] cnt_r;
  wire logic take = swap_start && !swap_busy;
  // ------------------------------------------------------------
  // swap length tracker
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      len_r <= 7'h00;
      cnt_r <= 7'h00;
    end else if (take) begin
      len_r <= OVERLAP_BASE + {1'b0, cfg.overlap_delay, 1'b0};
      cnt_r <= 7'h00;
    end else if (swap_busy) begin
      cnt_r <= cnt_r + 7'h01;
    end
  end
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  AST_RD_REF: assert property (reg_rd && reg_addr == OFS_REFERENCE_TRIM |=>
    reg_rdata == {4'h0, $past(cfg.reference_trim_field)}) else $error("ref trim read");
  AST_RD_TERM: assert property (reg_rd && reg_addr == OFS_TERM_TRIM_C |=>
    reg_rdata == $past(cfg.term_trim_c)) else $error("term trim read");
  AST_RD_DITHER: assert property (reg_rd && reg_addr == OFS_DITHER_CONTROL |=>
    reg_rdata == {5'h00, $past(cfg.rounding_to_offset), $past(cfg.dither_large),
    $past(cfg.dither_on)}) else $error("dither read");
  AST_WR_OVERLAP: assert property (reg_wr && reg_addr == OFS_SWAP_OVERLAP_DELAY |=>
    cfg.overlap_delay == $past(reg_wdata[4:0])) else $error("overlap write");
  AST_WR_STEER: assert property (reg_wr && reg_addr == OFS_SWAP_STEERING_DELAY |=>
    cfg.steering_delay == $past(reg_wdata[4:0])) else $error("steering write");
  AST_FUSE: assert property ($rose(arst_n) |=>
    cfg.term_trim_a == $past(fuse_image.term_trim_a) &&
    cfg.reference_trim_field == $past(fuse_image.reference_trim_field) &&
    {cfg.rounding_to_offset, cfg.dither_large, cfg.dither_on} == $past(fuse_image.dither_ctrl))
    else $error("fuse image not loaded");
  AST_SWAP_RISE: assert property (take |=> swap_busy && swap_overlap)
    else $error("swap did not start");
  AST_SWAP_MAX: assert property (swap_busy |-> cnt_r < len_r)
    else $error("overlap too long");
  AST_SWAP_END: assert property ($fell(swap_busy) |-> cnt_r == len_r)
    else $error("overlap length wrong");
  AST_SEL_QUIET: assert property (!swap_busy && !$past(swap_busy) |-> $stable(steer_sel))
    else $error("steer select moved outside swap");
endmodule

bind adc_trim_swap_dither_regs trim_regs_checker #(.ADDR_W(ADDR_W)) i_trim_regs_checker (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuse_image(fuse_image),
  .cfg(cfg), .swap_start(swap_start), .swap_sel_in(swap_sel_in), .swap_busy(swap_busy),
  .swap_overlap(swap_overlap), .steer_sel(steer_sel));

// ### tb_adc_trim_swap_dither_regs.sv
`timescale 1ns/10ps
module tb_adc_trim_swap_dither_regs
  import trim_swap_pkg::*;
;
  logic clk_sys, arst_n, reg_wr, reg_rd, swap_start, swap_sel_in;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic swap_busy, swap_overlap, steer_sel;
  fuse_image_t fuse_image;
  trim_cfg_t cfg;
  int bad_count;
  int comparisons;
  // clock source
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  adc_trim_swap_dither_regs #(.ADDR_W(12)) i_adc_trim_swap_dither_regs (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuse_image(fuse_image),
    .cfg(cfg), .swap_start(swap_start), .swap_sel_in(swap_sel_in), .swap_busy(swap_busy),
    .swap_overlap(swap_overlap), .steer_sel(steer_sel));
  // ------------------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_fuse;
    rd(OFS_REFERENCE_TRIM, {4'h0, fuse_image.reference_trim_field});
    rd(OFS_TERM_TRIM_A, fuse_image.term_trim_a);
    rd(OFS_TERM_TRIM_B, fuse_image.term_trim_b);
    rd(OFS_TERM_TRIM_C, fuse_image.term_trim_c);
    rd(OFS_TERM_TRIM_D, fuse_image.term_trim_d);
    chk("cfg_term_a", fuse_image.term_trim_a, cfg.term_trim_a);
    chk("cfg_term_b", fuse_image.term_trim_b, cfg.term_trim_b);
    chk("cfg_term_c", fuse_image.term_trim_c, cfg.term_trim_c);
    rd(OFS_DITHER_CONTROL, {5'h00, fuse_image.dither_ctrl});
    rd(OFS_SWAP_OVERLAP_DELAY, 8'h08);
    rd(OFS_SWAP_STEERING_DELAY, 8'h07);
    $display("test fuse_load done");
  endtask
  task automatic t_rw;
    wr(OFS_REFERENCE_TRIM, 8'h05);
    rd(OFS_REFERENCE_TRIM, 8'h05);
    chk("cfg_ref", 8'h05, {4'h0, cfg.reference_trim_field});
    wr(OFS_TERM_TRIM_D, 8'hFF);
    rd(OFS_TERM_TRIM_D, 8'hFF);
    chk("cfg_term_d", 8'hFF, cfg.term_trim_d);
    wr(12'h07D, 8'hA5);
    rd(12'h07D, 8'h00);
    wr(OFS_SWAP_OVERLAP_DELAY, 8'h1F);
    rd(OFS_SWAP_OVERLAP_DELAY, 8'h1F);
    for (int m = 0; m < 8; m++) begin
      wr(OFS_DITHER_CONTROL, m[7:0]);
      #1;
      chk("dither", m[7:0], {5'h00, cfg.rounding_to_offset, cfg.dither_large, cfg.dither_on});
    end
    $display("test read_write done");
  endtask
  task automatic t_swap(input logic [4:0] d, input logic [4:0] s, input logic rej);
    int n;
    int first;
    int first_exp;
    logic sel;
    n = 0;
    first = 0;
    sel = ~steer_sel;
    // steering lands after its delay, or at overlap end if that comes first
    first_exp = (s > 4 + 2 * d) ? 5 + 2 * d : s + 1;
    wr(OFS_SWAP_OVERLAP_DELAY, {3'h0, d});
    wr(OFS_SWAP_STEERING_DELAY, {3'h0, s});
    @(posedge clk_sys);
    swap_start <= 1'b1;
    swap_sel_in <= sel;
    // count busy cycles, find the select change, retry start mid-swap when rej is set
    for (int i = 1; i < 80; i++) begin
      @(posedge clk_sys);
      swap_start <= rej && (i == 2);
      swap_sel_in <= (rej && i == 2) ? ~sel : sel;
      #1;
      if (swap_overlap !== swap_busy) n = 200;
      if (swap_busy === 1'b1) n++;
      if (first == 0 && steer_sel === sel) first = i;
    end
    chk("busy_cycles", 8'(4 + 2 * d), n[7:0]);
    chk("steer_cycle", 8'(first_exp), first[7:0]);
    chk("steer_sel", {7'h00, sel}, {7'h00, steer_sel});
    $display("test swap done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    arst_n = 1'b0;
    {reg_wr, reg_rd, swap_start, swap_sel_in} = 4'h0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    fuse_image = {4'hA, 8'h5A, 8'hC3, 8'h81, 8'h3E, 3'h5};
    bad_count = 0;
    comparisons = 0;
    @(posedge clk_sys);
    #1;
    chk("rst_overlap", 8'h08, {3'h0, cfg.overlap_delay});
    chk("rst_steering", 8'h07, {3'h0, cfg.steering_delay});
    @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_fuse();
    t_rw();
    t_swap(5'h00, 5'h01, 1'b0);
    t_swap(5'h07, 5'h00, 1'b1);
    t_swap(5'h1F, 5'h05, 1'b1);
    t_swap(5'h00, 5'h1F, 1'b0);
    wrap_up();
  end
endmodule
